// >>> core/cps_startup.sv
`timescale 1ns/10ps
// Contract
// - Self-test at power-on, blink I/O error LED
// - After pass, scan terminals into hidden list
// - Error halts; clean start enters fieldbus start
// - Halt left only by new power-up
// - Switch setup only with end terminal alone
// - All switches on: restore factory, LED pattern
// - All switches off: link setup, LEDs steady
// - Switches 1-3 pick rate, auto, duplex
// - Switch 10 on stores link, LEDs flash
// - Registers hold address bytes 1-3, defaults
// - Tables persist only on software reset
// - Switches 9, 10 off: network addressing
// - Adopt address on 123-byte echo request
// - Network address kept in nonvolatile store
// - Short error flash at start in network mode
// - Switches 1-9 on keep BootP address
// - Only switch 9 on: BootP each power-up
// - Dynamic BootP address survives only software reset
module cps_startup #(
    parameter logic [23:0] BLINK_CYC = cps_pkg::BLINK_CYC,
    parameter logic [23:0] FLASH_CYC = cps_pkg::FLASH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Configuration switches, bit 0 is switch 1
    input wire logic [9:0] dip_i,
    // Self-test and terminal scan results
    input wire logic selftest_done_i,
    input wire logic selftest_pass_i,
    input wire logic scan_done_i,
    input wire logic scan_err_i,
    input wire logic [7:0] term_count_i,
    input wire logic end_term_i,
    // Software reset request
    input wire logic soft_reset_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // Network events
    input wire logic echo_valid_i,
    input wire logic [15:0] echo_len_i,
    input wire logic [31:0] echo_dst_ip_i,
    input wire logic bootp_valid_i,
    input wire logic [31:0] bootp_ip_i,
    // Nonvolatile store
    input wire logic [31:0] nv_ip_i,
    input wire cps_pkg::cps_link_t nv_link_i,
    output logic nv_wr_o,
    output logic [31:0] nv_ip_o,
    output cps_pkg::cps_link_t nv_link_o,
    // Status
    output cps_pkg::cps_state_t state_o,
    output cps_pkg::cps_ipmode_t ip_mode_o,
    output logic [31:0] ip_addr_o,
    output cps_pkg::cps_link_t link_o,
    output logic bootp_req_o,
    output cps_pkg::cps_led_t led_o
);

    logic [9:0] dip_meta_reg;
    logic [9:0] dip_s_reg;
    logic accept_prev_reg;
    logic boot_done_reg;
    logic [7:0] term_list_reg;
    logic end_seen_reg;
    logic [15:0] ip_low_reg;
    logic [7:0] ip_three_reg;
    logic [31:0] ip_net_reg;
    logic bootp_have_reg;
    logic [31:0] bootp_ip_reg;
    logic accepted_reg;
    logic [23:0] flash_reg;
    logic blink;
    logic end_only;
    logic all_on;
    logic all_off;
    logic go_defaults;
    logic go_eth;
    logic accept_rise;
    logic echo_adopt;
    logic bootp_take;
    logic sw_net;
    logic soft_go;

    // Blink source for indicators
    cps_blink u_blink (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .half_i(BLINK_CYC),
        .phase_o(blink)
    );

    // Switch pins synchronised
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dip_meta_reg <= 10'h000;
            dip_s_reg <= 10'h000;
            accept_prev_reg <= 1'b0;
        end else begin
            dip_meta_reg <= dip_i;
            dip_s_reg <= dip_meta_reg;
            accept_prev_reg <= dip_s_reg[cps_pkg::SW_ACCEPT];
        end
    end

    // Decode helpers
    assign end_only = end_seen_reg && (term_list_reg == 8'h00);
    assign all_on = &dip_s_reg;
    assign all_off = ~|dip_s_reg;
    assign go_defaults = (state_o == cps_pkg::ST_DECIDE) && end_only && all_on;
    assign go_eth = (state_o == cps_pkg::ST_DECIDE) && end_only && all_off;
    assign accept_rise = dip_s_reg[cps_pkg::SW_ACCEPT] && !accept_prev_reg;
    assign sw_net = !dip_s_reg[cps_pkg::SW_BOOTP] && !dip_s_reg[cps_pkg::SW_ACCEPT];
    assign echo_adopt = (state_o == cps_pkg::ST_RUN) && (ip_mode_o == cps_pkg::IPM_NET) && echo_valid_i
                        && (echo_len_i == cps_pkg::ECHO_ADOPT_LEN);
    assign bootp_take = (state_o == cps_pkg::ST_RUN) && bootp_valid_i && !bootp_have_reg
                        && ((ip_mode_o == cps_pkg::IPM_BOOTP_STATIC) || (ip_mode_o == cps_pkg::IPM_BOOTP_DYN));
    assign soft_go = soft_reset_i && (state_o != cps_pkg::ST_HALT);

    // Start-up sequence
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_o <= cps_pkg::ST_SELFTEST;
        end else if (soft_go) begin
            state_o <= cps_pkg::ST_SELFTEST;
        end else begin
            case (state_o)
                cps_pkg::ST_SELFTEST: begin
                    if (selftest_done_i) begin
                        state_o <= selftest_pass_i ? cps_pkg::ST_SCAN : cps_pkg::ST_HALT;
                    end
                end
                cps_pkg::ST_SCAN: begin
                    if (scan_done_i) begin
                        state_o <= scan_err_i ? cps_pkg::ST_HALT : cps_pkg::ST_DECIDE;
                    end
                end
                cps_pkg::ST_DECIDE: begin
                    if (go_defaults) begin
                        state_o <= cps_pkg::ST_DEFAULTS;
                    end else if (go_eth) begin
                        state_o <= cps_pkg::ST_ETHPARAM;
                    end else begin
                        state_o <= cps_pkg::ST_RUN;
                    end
                end
                cps_pkg::ST_HALT: state_o <= cps_pkg::ST_HALT;
                cps_pkg::ST_DEFAULTS, cps_pkg::ST_ETHPARAM, cps_pkg::ST_RUN: state_o <= state_o;
                default: state_o <= cps_pkg::ST_HALT;
            endcase
        end
    end

    // Hidden terminal structure list
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            term_list_reg <= 8'h00;
            end_seen_reg <= 1'b0;
        end else if (state_o == cps_pkg::ST_SCAN && scan_done_i && !scan_err_i) begin
            term_list_reg <= term_count_i;
            end_seen_reg <= end_term_i;
        end
    end

    // Address source chosen once per start
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ip_mode_o <= cps_pkg::IPM_NONE;
        end else if (state_o == cps_pkg::ST_DECIDE) begin
            if (go_defaults || go_eth) begin
                ip_mode_o <= cps_pkg::IPM_NONE;
            end else if (sw_net) begin
                ip_mode_o <= cps_pkg::IPM_NET;
            end else if (dip_s_reg[cps_pkg::SW_BOOTP] && (&dip_s_reg[7:0])) begin
                ip_mode_o <= cps_pkg::IPM_BOOTP_STATIC;
            end else if (dip_s_reg[cps_pkg::SW_BOOTP]) begin
                ip_mode_o <= cps_pkg::IPM_BOOTP_DYN;
            end else begin
                ip_mode_o <= cps_pkg::IPM_SWITCH;
            end
        end
    end

    // Address registers, loaded from the store once after power-up
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_done_reg <= 1'b0;
            ip_low_reg <= {cps_pkg::IP_BYTE2_RST, cps_pkg::IP_BYTE1_RST};
            ip_three_reg <= cps_pkg::IP_BYTE3_RST;
            ip_net_reg <= 32'h00000000;
            link_o <= cps_pkg::LINK_RST;
        end else if (!boot_done_reg) begin
            boot_done_reg <= 1'b1;
            ip_low_reg <= {nv_ip_i[23:16], nv_ip_i[31:24]};
            ip_three_reg <= nv_ip_i[15:8];
            ip_net_reg <= nv_ip_i;
            link_o <= nv_link_i;
        end else if (go_defaults) begin
            ip_low_reg <= {cps_pkg::IP_BYTE2_RST, cps_pkg::IP_BYTE1_RST};
            ip_three_reg <= cps_pkg::IP_BYTE3_RST;
            link_o <= cps_pkg::LINK_RST;
        end else begin
            if (reg_wr_i && reg_addr_i == cps_pkg::REG_IP_LOW) begin
                ip_low_reg <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == cps_pkg::REG_IP_THREE) begin
                ip_three_reg <= reg_wdata_i[7:0];
            end
            if (echo_adopt) begin
                ip_net_reg <= echo_dst_ip_i;
            end
            if (state_o == cps_pkg::ST_ETHPARAM && accept_rise && !accepted_reg) begin
                link_o <= {dip_s_reg[cps_pkg::SW_RATE], dip_s_reg[cps_pkg::SW_AUTO],
                           dip_s_reg[cps_pkg::SW_DUPLEX]};
            end
        end
    end

    // Register read port, high byte of index 1 reads zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == cps_pkg::REG_IP_LOW) begin
                reg_rdata_o <= ip_low_reg;
            end else if (reg_addr_i == cps_pkg::REG_IP_THREE) begin
                reg_rdata_o <= {8'h00, ip_three_reg};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end

    // BootP address, kept over software reset, lost at power-off
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bootp_have_reg <= 1'b0;
            bootp_ip_reg <= 32'h00000000;
            bootp_req_o <= 1'b0;
        end else begin
            if (state_o == cps_pkg::ST_DECIDE && !go_defaults && !go_eth && !sw_net
                && dip_s_reg[cps_pkg::SW_BOOTP] && (&dip_s_reg[7:0])) begin
                bootp_have_reg <= 1'b1;
                bootp_ip_reg <= ip_net_reg;
            end else if (bootp_take) begin
                bootp_have_reg <= 1'b1;
                bootp_ip_reg <= bootp_ip_i;
            end
            bootp_req_o <= (state_o == cps_pkg::ST_RUN) && !bootp_have_reg
                           && ((ip_mode_o == cps_pkg::IPM_BOOTP_STATIC)
                               || (ip_mode_o == cps_pkg::IPM_BOOTP_DYN));
        end
    end

    // Active address
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ip_addr_o <= 32'h00000000;
        end else begin
            case (ip_mode_o)
                cps_pkg::IPM_SWITCH: ip_addr_o <= {ip_low_reg[7:0], ip_low_reg[15:8], ip_three_reg,
                                                   dip_s_reg[7:0]};
                cps_pkg::IPM_NET: ip_addr_o <= ip_net_reg;
                cps_pkg::IPM_BOOTP_STATIC, cps_pkg::IPM_BOOTP_DYN: begin
                    ip_addr_o <= bootp_have_reg ? bootp_ip_reg : 32'h00000000;
                end
                default: ip_addr_o <= 32'h00000000;
            endcase
        end
    end

    // Nonvolatile store writes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nv_wr_o <= 1'b0;
            nv_ip_o <= 32'h00000000;
            nv_link_o <= cps_pkg::LINK_RST;
        end else begin
            nv_wr_o <= 1'b0;
            if (soft_go) begin
                nv_wr_o <= 1'b1;
                nv_ip_o <= {ip_low_reg[7:0], ip_low_reg[15:8], ip_three_reg, ip_net_reg[7:0]};
                nv_link_o <= link_o;
            end else if (go_defaults) begin
                nv_wr_o <= 1'b1;
                nv_ip_o <= {cps_pkg::IP_BYTE1_RST, cps_pkg::IP_BYTE2_RST, cps_pkg::IP_BYTE3_RST,
                            cps_pkg::IP_BYTE4_RST};
                nv_link_o <= cps_pkg::LINK_RST;
            end else if (state_o == cps_pkg::ST_ETHPARAM && accept_rise && !accepted_reg) begin
                nv_wr_o <= 1'b1;
                nv_link_o <= {dip_s_reg[cps_pkg::SW_RATE], dip_s_reg[cps_pkg::SW_AUTO],
                              dip_s_reg[cps_pkg::SW_DUPLEX]};
            end else if (echo_adopt) begin
                nv_wr_o <= 1'b1;
                nv_ip_o <= echo_dst_ip_i;
            end else if (bootp_take && ip_mode_o == cps_pkg::IPM_BOOTP_STATIC) begin
                nv_wr_o <= 1'b1;
                nv_ip_o <= bootp_ip_i;
            end
        end
    end

    // Link settings accepted flag and start-up flash timer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            accepted_reg <= 1'b0;
            flash_reg <= 24'h000000;
        end else begin
            if (state_o == cps_pkg::ST_ETHPARAM && accept_rise) begin
                accepted_reg <= 1'b1;
            end
            if (state_o == cps_pkg::ST_DECIDE && !go_defaults && !go_eth && sw_net) begin
                flash_reg <= FLASH_CYC;
            end else if (flash_reg != 24'h000000) begin
                flash_reg <= flash_reg - 24'h000001;
            end
        end
    end

    // Indicators
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            led_o <= 3'h0;
        end else begin
            case (state_o)
                cps_pkg::ST_SELFTEST: led_o <= {1'b0, blink, 1'b0};
                cps_pkg::ST_DEFAULTS: led_o <= {blink, ~blink, 1'b1};
                cps_pkg::ST_ETHPARAM: begin
                    led_o <= accepted_reg ? {blink, blink, 1'b0} : 3'h6;
                end
                cps_pkg::ST_RUN: led_o <= {1'b1, 1'b0, flash_reg != 24'h000000};
                cps_pkg::ST_HALT: led_o <= 3'h3;
                default: led_o <= 3'h0;
            endcase
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_selftest_blink;
        (state_o == cps_pkg::ST_SELFTEST) && $past(state_o == cps_pkg::ST_SELFTEST)
            |-> led_o.io_err == $past(blink);
    endproperty
    a_selftest_blink: assert property (p_selftest_blink) else $error("io error led not blinking");

    property p_scan_capture;
        (state_o == cps_pkg::ST_SCAN) && scan_done_i && !scan_err_i && !soft_reset_i
            |=> term_list_reg == $past(term_count_i) && state_o == cps_pkg::ST_DECIDE;
    endproperty
    a_scan_capture: assert property (p_scan_capture) else $error("scan result not taken");

    property p_scan_halt;
        (state_o == cps_pkg::ST_SCAN) && scan_done_i && scan_err_i && !soft_reset_i
            |=> state_o == cps_pkg::ST_HALT ##1 led_o == 3'h3;
    endproperty
    a_scan_halt: assert property (p_scan_halt) else $error("scan error did not halt");

    property p_halt_stays;
        state_o == cps_pkg::ST_HALT |=> state_o == cps_pkg::ST_HALT [*4];
    endproperty
    a_halt_stays: assert property (p_halt_stays) else $error("left halt without power-up");

    property p_defaults;
        go_defaults && !soft_reset_i |=> nv_wr_o && nv_link_o == cps_pkg::LINK_RST
            ##1 led_o.err && (led_o.io_run != led_o.io_err);
    endproperty
    a_defaults: assert property (p_defaults) else $error("factory restore wrong");

    property p_eth_steady;
        (state_o == cps_pkg::ST_ETHPARAM) && !accepted_reg && !soft_reset_i
            |=> led_o.io_run && led_o.io_err && !led_o.err;
    endproperty
    a_eth_steady: assert property (p_eth_steady) else $error("link setup leds not steady");

    property p_eth_accept;
        (state_o == cps_pkg::ST_ETHPARAM) && accept_rise && !accepted_reg && !soft_reset_i
            |=> nv_wr_o && link_o == nv_link_o && nv_link_o == {$past(dip_s_reg[cps_pkg::SW_RATE]),
                $past(dip_s_reg[cps_pkg::SW_AUTO]), $past(dip_s_reg[cps_pkg::SW_DUPLEX])};
    endproperty
    a_eth_accept: assert property (p_eth_accept) else $error("link settings not stored");

    property p_reg_hi_zero;
        reg_rd_i && reg_addr_i == cps_pkg::REG_IP_THREE |=> reg_rdata_o[15:8] == 8'h00;
    endproperty
    a_reg_hi_zero: assert property (p_reg_hi_zero) else $error("unused byte not zero");

    property p_switch_byte;
        (ip_mode_o == cps_pkg::IPM_SWITCH) && $stable(dip_s_reg) |=> ip_addr_o[7:0] == $past(dip_s_reg[7:0]);
    endproperty
    a_switch_byte: assert property (p_switch_byte) else $error("byte four not from switches");

    property p_no_commit;
        !soft_go && !go_defaults && !echo_adopt && !bootp_take && (state_o != cps_pkg::ST_ETHPARAM)
            |=> !nv_wr_o;
    endproperty
    a_no_commit: assert property (p_no_commit) else $error("store written without cause");

    property p_echo_adopt;
        echo_adopt && !soft_reset_i |=> nv_wr_o && nv_ip_o == $past(echo_dst_ip_i)
            ##1 ip_addr_o == $past(echo_dst_ip_i, 2);
    endproperty
    a_echo_adopt: assert property (p_echo_adopt) else $error("echo address not adopted");

    c_run: cover property (state_o == cps_pkg::ST_RUN);
    c_halt: cover property (state_o == cps_pkg::ST_HALT);
    c_defaults: cover property (state_o == cps_pkg::ST_DEFAULTS);
    c_accept: cover property (accepted_reg && state_o == cps_pkg::ST_ETHPARAM);
    c_echo: cover property (echo_adopt);

endmodule : cps_startup

// >>> core/cps_pkg.sv
package cps_pkg;

    // Clock rate and indicator timing (20 MHz, 250 ms blink half period, 100 ms flash)
    localparam longint unsigned CLK_HZ = 64'h0000_0000_0131_2D00;
    localparam longint unsigned BLINK_HALF_MS = 64'h0000_0000_0000_00FA;
    localparam longint unsigned FLASH_MS = 64'h0000_0000_0000_0064;
    localparam longint unsigned MS_PER_S = 64'h0000_0000_0000_03E8;
    localparam logic [23:0] BLINK_CYC = 24'(BLINK_HALF_MS * CLK_HZ / MS_PER_S);
    localparam logic [23:0] FLASH_CYC = 24'(FLASH_MS * CLK_HZ / MS_PER_S);

    // Register offsets, word index on the register port
    localparam logic [7:0] REG_IP_LOW = 8'h00;
    localparam logic [7:0] REG_IP_THREE = 8'h01;

    // Address byte reset values
    localparam logic [7:0] IP_BYTE1_RST = 8'hAC;
    localparam logic [7:0] IP_BYTE2_RST = 8'h10;
    localparam logic [7:0] IP_BYTE3_RST = 8'h11;
    localparam logic [7:0] IP_BYTE4_RST = 8'h00;

    // Echo length that makes a new address valid (123 bytes)
    localparam logic [15:0] ECHO_ADOPT_LEN = 16'h007B;

    // Switch positions, bit 0 is switch 1
    localparam int SW_RATE = 0;
    localparam int SW_AUTO = 1;
    localparam int SW_DUPLEX = 2;
    localparam int SW_BOOTP = 8;
    localparam int SW_ACCEPT = 9;
    localparam int DIP_N = 10;

    // Link settings
    typedef struct packed {
        logic rate_100;
        logic auto_rate;
        logic full_duplex;
    } cps_link_t;
    localparam cps_link_t LINK_RST = 3'h7;

    // Indicators
    typedef struct packed {
        logic io_run;
        logic io_err;
        logic err;
    } cps_led_t;

    // Start-up sequence
    typedef enum logic [2:0] {
        ST_SELFTEST,
        ST_SCAN,
        ST_DECIDE,
        ST_DEFAULTS,
        ST_ETHPARAM,
        ST_RUN,
        ST_HALT
    } cps_state_t;

    // Address source
    typedef enum logic [2:0] {
        IPM_NONE,
        IPM_SWITCH,
        IPM_NET,
        IPM_BOOTP_STATIC,
        IPM_BOOTP_DYN
    } cps_ipmode_t;

endpackage : cps_pkg

// >>> core/cps_blink.sv
`timescale 1ns/10ps
module cps_blink (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Half period in cycles
    input wire logic [23:0] half_i,
    // Square wave
    output logic phase_o
);

    logic [23:0] cnt_reg;

    // Free running half period counter
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 24'h000000;
            phase_o <= 1'b0;
        end else if (cnt_reg >= half_i - 24'h000001) begin
            cnt_reg <= 24'h000000;
            phase_o <= ~phase_o;
        end else begin
            cnt_reg <= cnt_reg + 24'h000001;
        end
    end

endmodule : cps_blink

// >>> tb/cps_host.sv
`timescale 1ns/10ps
module cps_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Address exchange
    input wire logic bootp_req_i,
    input wire logic [31:0] ip_i,
    output logic bootp_valid_o,
    output logic [31:0] bootp_ip_o
);
    logic [3:0] wait_reg;
    // Slow server, one reply once a request has stood nine cycles
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_reg <= 4'h0;
            bootp_valid_o <= 1'b0;
        end else begin
            wait_reg <= bootp_req_i ? wait_reg + 4'h1 : 4'h0;
            bootp_valid_o <= (wait_reg == 4'h8);
        end
    end
    // Configured address only with the reply, garbage otherwise
    assign bootp_ip_o = bootp_valid_o ? ip_i : ~ip_i;
endmodule : cps_host

// >>> tb/test_coupler_startup_and_ip_config.sv
`timescale 1ns/10ps
module test_coupler_startup_and_ip_config;
    logic clk_i, rstn_i, selftest_done_i, selftest_pass_i, soft_reset_i, reg_wr_i, reg_rd_i;
    logic echo_valid_i, bootp_valid_i, nv_wr_o, bootp_req_o, rd_d, scan_err_i, end_term_i;
    logic [9:0] dip_i;
    logic [7:0] term_count_i, reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, echo_len_i, w;
    logic [31:0] echo_dst_ip_i, bootp_ip_i, host_ip, nv_ip_o, ip_addr_o, r;
    cps_pkg::cps_link_t nv_link_o, link_o;
    cps_pkg::cps_state_t state_o;
    cps_pkg::cps_ipmode_t ip_mode_o;
    cps_pkg::cps_led_t led_o;
    logic [15:0] exp_q[$];
    int error_cnt, compares, cyc;

    cps_startup #(.BLINK_CYC(24'h000004), .FLASH_CYC(24'h000006)) i_dut (
        .clk_i, .rstn_i, .dip_i, .selftest_done_i, .selftest_pass_i, .scan_done_i(1'b1),
        .scan_err_i, .term_count_i, .end_term_i, .soft_reset_i, .reg_wr_i, .reg_rd_i,
        .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .echo_valid_i, .echo_len_i, .echo_dst_ip_i,
        .bootp_valid_i, .bootp_ip_i, .nv_ip_i(32'hAC101100), .nv_link_i(3'h7), .nv_wr_o, .nv_ip_o,
        .nv_link_o, .state_o, .ip_mode_o, .ip_addr_o, .link_o, .bootp_req_o, .led_o);
    cps_host i_host (.clk_i, .rstn_i, .bootp_req_i(bootp_req_o), .ip_i(host_ip),
        .bootp_valid_o(bootp_valid_i), .bootp_ip_o(bootp_ip_i));

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // Read answers compared against the oldest note
    always @(posedge clk_i) rd_d <= reg_rd_i;
    always @(negedge clk_i) begin
        if (rd_d) check(32'(reg_rdata_o), 32'(exp_q.pop_front()));
    end

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic boot(input logic [9:0] d, input logic pass, input logic [7:0] n);
        rstn_i <= 1'b0;
        dip_i <= d;
        term_count_i <= n;
        selftest_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        selftest_pass_i <= pass;
        selftest_done_i <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask : boot

    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [15:0] d);
        reg_wr_i <= wr;
        reg_rd_i <= ~wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (!wr) exp_q.push_back(d);
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : reg_op

    task automatic pulse_soft;
        soft_reset_i <= 1'b1;
        @(posedge clk_i);
        soft_reset_i <= 1'b0;
    endtask : pulse_soft

    task automatic wait_nv;
        int k;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (nv_wr_o !== 1'b1 && k < 8);
        check(32'(nv_wr_o), 32'h1);
        @(posedge clk_i);
    endtask : wait_nv

    initial begin
        {rstn_i, dip_i, selftest_done_i, selftest_pass_i, term_count_i, soft_reset_i, scan_err_i} = '0;
        end_term_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, echo_valid_i, echo_len_i, echo_dst_ip_i} = '0;
        {error_cnt, compares, cyc, rd_d} = '0;
        r = $urandom(5);
        host_ip = $urandom;
        boot(10'h000, 1'b1, 8'h01);
        check(32'(state_o), 32'(cps_pkg::ST_RUN));
        check(32'(ip_mode_o), 32'(cps_pkg::IPM_NET));
        check(ip_addr_o, 32'hAC101100);
        check(32'(led_o), 32'h5);
        reg_op(1'b0, 8'h00, 16'h10AC);
        reg_op(1'b0, 8'h01, 16'h0011);
        w = 16'($urandom);
        reg_op(1'b1, 8'h00, w);
        reg_op(1'b1, 8'h05, 16'hFFFF);
        reg_op(1'b0, 8'h00, w);
        reg_op(1'b0, 8'h05, 16'h0000);
        check(32'(led_o), 32'h4);
        r = $urandom;
        echo_valid_i <= 1'b1;
        echo_len_i <= 16'h007A;
        echo_dst_ip_i <= ~r;
        @(posedge clk_i);
        echo_len_i <= 16'h007B;
        echo_dst_ip_i <= r;
        @(posedge clk_i);
        echo_valid_i <= 1'b0;
        wait_nv();
        check(nv_ip_o, r);
        repeat (3) @(posedge clk_i);
        check(ip_addr_o, r);
        pulse_soft();
        wait_nv();
        check(nv_ip_o, {w[7:0], w[15:8], 8'h11, r[7:0]});
        $display("network address test done");
        boot(10'h000, 1'b0, 8'h01);
        pulse_soft();
        repeat (3) @(posedge clk_i);
        check(32'(state_o), 32'(cps_pkg::ST_HALT));
        check(32'(led_o), 32'h3);
        scan_err_i <= 1'b1;
        boot(10'h000, 1'b1, 8'h01);
        check(32'(state_o), 32'(cps_pkg::ST_HALT));
        scan_err_i <= 1'b0;
        $display("halt test done");
        w = 16'($urandom);
        boot({2'b10, w[7:0]}, 1'b1, 8'h00);
        check(32'(ip_mode_o), 32'(cps_pkg::IPM_SWITCH));
        check(32'(ip_addr_o[7:0]), 32'(w[7:0]));
        boot(10'h100, 1'b1, 8'h02);
        repeat (20) @(posedge clk_i);
        check(ip_addr_o, host_ip);
        check(32'(bootp_req_o), 32'h0);
        pulse_soft();
        repeat (20) @(posedge clk_i);
        check(ip_addr_o, host_ip);
        boot(10'h3FF, 1'b1, 8'h01);
        check(32'(ip_mode_o), 32'(cps_pkg::IPM_BOOTP_STATIC));
        check(ip_addr_o, 32'hAC101100);
        end_term_i <= 1'b0;
        boot(10'h3FF, 1'b1, 8'h00);
        check(32'(state_o), 32'(cps_pkg::ST_RUN));
        end_term_i <= 1'b1;
        $display("address mode test done");
        boot(10'h3FF, 1'b1, 8'h00);
        check(32'(state_o), 32'(cps_pkg::ST_DEFAULTS));
        boot(10'h000, 1'b1, 8'h00);
        check(32'(state_o), 32'(cps_pkg::ST_ETHPARAM));
        check(32'(led_o), 32'h6);
        dip_i <= 10'h203;
        wait_nv();
        check(32'(nv_link_o), 32'h6);
        check(32'(link_o), 32'h6);
        $display("switch setup test done");
        tally_and_finish();
    end
endmodule : test_coupler_startup_and_ip_config
